// *** uer_pkg.sv ***
// constants and carrier types for the uncorrectable error report register bank
package uer_pkg;

  localparam int DATA_W = 32;
  localparam int MIN_ADDR_W = 12;
  localparam int HDR_DWORDS = 4;

  localparam logic [11:0] OFF_CAP_HEADER = 12'h100;
  localparam logic [11:0] OFF_STATUS = 12'h104;
  localparam logic [11:0] OFF_MASK = 12'h108;
  localparam logic [11:0] OFF_SEVERITY = 12'h10C;
  localparam logic [11:0] OFF_CAP_CTRL = 12'h118;
  localparam logic [11:0] OFF_HDR_LOG0 = 12'h11C;

  localparam int CAP_ID_LSB = 0;
  localparam int CAP_VER_LSB = 16;
  localparam int CAP_NEXT_LSB = 20;
  localparam logic [15:0] CAP_ID = 16'h0001;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] CAP_NEXT = 12'h140;

  localparam int FEP_LSB = 0;
  localparam int FEP_W = 5;

  localparam logic [31:0] ERR_BITS = 32'h003FF011;
  localparam logic [31:0] STATUS_RESET = 32'h00000000;
  localparam logic [31:0] MASK_RESET = 32'h00000000;
  localparam logic [31:0] SEVERITY_RESET = 32'h00000011;
  localparam logic [4:0] FEP_RESET = 5'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // detect bit i is a one-cycle pulse for the error at status bit i
  typedef struct packed {
    logic [31:0] detect;
    logic [127:0] header;
  } uer_event_t;

  typedef struct packed {
    logic valid;
    logic fatal;
  } uer_msg_t;

endpackage : uer_pkg

// *** uer_regs.sv ***
// uncorrectable error report registers behind an AXI4-Lite slave
//
// How it works
// R1 - header bits 15:0 read the fixed capability identifier 0001h.
// R2 - header bits 19:16 read version 1h; writes do nothing.
// R3 - header bits 31:20 read next pointer 140h, read-only.
// R4 - training error sets sticky status bit 0; write one clears; resets 0.
// R5 - data link protocol error sets sticky status bit 4, write one clears.
// R6 - poisoned packet received or generated sets sticky status bit 12.
// R7 - flow control protocol error sets sticky status bit 13.
// R8 - completion timeout sets sticky status bit 14.
// R9 - completer abort sets sticky status bit 15.
// R10 - unexpected completion sets sticky status bit 16.
// R11 - receive buffer overflow sets sticky status bit 17.
// R12 - malformed packet received sets sticky status bit 18.
// R13 - end-to-end crc failure sets sticky status bit 19.
// R14 - unsupported request sets sticky status bit 20.
// R15 - access control violation sets sticky status bit 21.
// R16 - mask bit 0 set blocks header logging and messaging of training errors.
// R17 - mask bit 4 blocks logging and messaging of data link errors.
// R18 - mask bits 12 to 20 each block their own event; reset 0.
// R19 - mask bit 21 blocks access control violations like the others.
// R20 - reserved bits read zero and ignore writes.
// R21 - severity bit chooses fatal or non-fatal; bits 0 and 4 reset to 1.
// R22 - first unmasked error captures four header dwords big-endian into the log.
// R23 - five-bit pointer reports the status bit of the first logged error.
//
// Register access over AXI4-Lite was left to the implementer.
module uer_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input uer_pkg::uer_event_t errEvent,
  output uer_pkg::uer_msg_t errMsg
);

  generate
    if (ADDR_W < uer_pkg::MIN_ADDR_W) begin : g_bad_addr_w
      $error("uer_regs: ADDR_W too small for the register map");
    end
  endgenerate

  // whole block state in one record; next value built in one place
  typedef struct packed {
    logic awTaken;
    logic [ADDR_W-1:0] awAddr;
    logic wTaken;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic [31:0] status;
    logic [31:0] mask;
    logic [31:0] severity;
    logic [4:0] fep;
    logic [127:0] hdrLog;
    uer_pkg::uer_msg_t msg;
  } uer_state_t;

  uer_state_t s_q;
  uer_state_t s_d;

  // low two address bits ignored; any byte address inside a word hits it
  function automatic logic hit(logic [ADDR_W-1:0] a, logic [11:0] off);
    hit = (a >> 2) == (ADDR_W'(off) >> 2);
  endfunction : hit

  function automatic logic [31:0] byteMask(logic [3:0] strb);
    byteMask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction : byteMask

  function automatic logic [31:0] capHeader();
    logic [31:0] v;
    v = '0;
    v[uer_pkg::CAP_ID_LSB +: 16] = uer_pkg::CAP_ID; // R1
    v[uer_pkg::CAP_VER_LSB +: 4] = uer_pkg::CAP_VERSION; // R2
    v[uer_pkg::CAP_NEXT_LSB +: 12] = uer_pkg::CAP_NEXT; // R3
    capHeader = v;
  endfunction : capHeader

  function automatic logic isHdrLog(logic [ADDR_W-1:0] a, int k);
    isHdrLog = hit(a, 12'(uer_pkg::OFF_HDR_LOG0 + 12'(4 * k)));
  endfunction : isHdrLog

  // unmapped words answer with an error response and drop the write
  function automatic logic mapped(logic [ADDR_W-1:0] a);
    logic m;
    m = hit(a, uer_pkg::OFF_CAP_HEADER) || hit(a, uer_pkg::OFF_STATUS) || hit(a, uer_pkg::OFF_MASK);
    m = m || hit(a, uer_pkg::OFF_SEVERITY) || hit(a, uer_pkg::OFF_CAP_CTRL);
    for (int k = 0; k < uer_pkg::HDR_DWORDS; k++) begin
      m = m || isHdrLog(a, k);
    end
    mapped = m;
  endfunction : mapped

  function automatic logic [31:0] readWord(logic [ADDR_W-1:0] a, uer_state_t st);
    logic [31:0] v;
    v = '0;
    if (hit(a, uer_pkg::OFF_CAP_HEADER)) begin
      v = capHeader();
    end
    if (hit(a, uer_pkg::OFF_STATUS)) begin
      v = st.status & uer_pkg::ERR_BITS; // R20
    end
    if (hit(a, uer_pkg::OFF_MASK)) begin
      v = st.mask & uer_pkg::ERR_BITS;
    end
    if (hit(a, uer_pkg::OFF_SEVERITY)) begin
      v = st.severity & uer_pkg::ERR_BITS;
    end
    if (hit(a, uer_pkg::OFF_CAP_CTRL)) begin
      v[uer_pkg::FEP_LSB +: uer_pkg::FEP_W] = st.fep; // R23
    end
    for (int k = 0; k < uer_pkg::HDR_DWORDS; k++) begin
      if (isHdrLog(a, k)) begin
        v = st.hdrLog[32 * k +: 32];
      end
    end
    readWord = v;
  endfunction : readWord

  // header byte 0 lands in bits 31:24 of the first log dword
  function automatic logic [127:0] bigEndian(logic [127:0] h);
    logic [127:0] v;
    v = '0;
    for (int k = 0; k < uer_pkg::HDR_DWORDS; k++) begin
      for (int b = 0; b < 4; b++) begin
        v[32 * k + 8 * (3 - b) +: 8] = h[8 * (4 * k + b) +: 8];
      end
    end
    bigEndian = v;
  endfunction : bigEndian

  function automatic logic [4:0] lowestBit(logic [31:0] v);
    logic [4:0] p;
    p = '0;
    for (int i = 31; i >= 0; i--) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    lowestBit = p;
  endfunction : lowestBit

  logic awReady;
  logic wReady;
  logic arReady;
  logic writeNow;
  logic [31:0] unmasked;
  logic logEmpty;
  logic [4:0] firstPos;
  logic [127:0] hdrSwapped;

  // a new write waits until the response is gone; one write in flight
  assign awReady = !s_q.awTaken && !s_q.bValid;
  assign wReady = !s_q.wTaken && !s_q.bValid;
  assign arReady = !s_q.rValid;
  assign writeNow = s_q.awTaken && s_q.wTaken;
  assign unmasked = errEvent.detect & ~s_q.mask & uer_pkg::ERR_BITS; // R16 R17 R18 R19
  assign logEmpty = !s_q.status[s_q.fep];
  // named copies so the checks can look one cycle back at them
  assign firstPos = lowestBit(unmasked);
  assign hdrSwapped = bigEndian(errEvent.header);

  assign s_axi_awready = awReady;
  assign s_axi_wready = wReady;
  assign s_axi_arready = arReady;
  assign s_axi_bvalid = s_q.bValid;
  assign s_axi_bresp = s_q.bResp;
  assign s_axi_rvalid = s_q.rValid;
  assign s_axi_rdata = s_q.rData;
  assign s_axi_rresp = s_q.rResp;
  assign errMsg = s_q.msg;

  always_comb begin
    logic [31:0] bm;
    logic [31:0] clr;
    bm = '0;
    clr = '0;
    s_d = s_q;
    if (s_q.rValid && s_axi_rready) begin
      s_d.rValid = 1'b0;
    end
    if (s_axi_arvalid && arReady) begin
      s_d.rValid = 1'b1;
      s_d.rData = readWord(s_axi_araddr, s_q);
      s_d.rResp = mapped(s_axi_araddr) ? uer_pkg::RESP_OKAY : uer_pkg::RESP_SLVERR;
    end
    if (s_axi_awvalid && awReady) begin
      s_d.awTaken = 1'b1;
      s_d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady) begin
      s_d.wTaken = 1'b1;
      s_d.wData = s_axi_wdata;
      s_d.wStrb = s_axi_wstrb;
    end
    if (s_q.bValid && s_axi_bready) begin
      s_d.bValid = 1'b0;
    end
    if (writeNow) begin
      s_d.awTaken = 1'b0;
      s_d.wTaken = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = mapped(s_q.awAddr) ? uer_pkg::RESP_OKAY : uer_pkg::RESP_SLVERR;
      bm = byteMask(s_q.wStrb);
      if (hit(s_q.awAddr, uer_pkg::OFF_STATUS)) begin
        clr = s_q.wData & bm & uer_pkg::ERR_BITS; // R4 R5
      end
      if (hit(s_q.awAddr, uer_pkg::OFF_MASK)) begin
        s_d.mask = ((s_q.mask & ~bm) | (s_q.wData & bm)) & uer_pkg::ERR_BITS; // R17 R18 R19 R20
      end
      if (hit(s_q.awAddr, uer_pkg::OFF_SEVERITY)) begin
        s_d.severity = ((s_q.severity & ~bm) | (s_q.wData & bm)) & uer_pkg::ERR_BITS; // R21
      end
    end
    // set beats clear: an event in the clearing cycle stays recorded
    s_d.status = ((s_q.status & ~clr) | errEvent.detect) & uer_pkg::ERR_BITS; // R4 R5 R6 R7 R8 R9 R10 R11 R12 R13 R14 R15
    // log holds until software clears the status bit the pointer names
    if ((|unmasked) && logEmpty) begin
      s_d.fep = firstPos; // R23
      s_d.hdrLog = hdrSwapped; // R22
    end
    s_d.msg.valid = |unmasked; // R16
    s_d.msg.fatal = |(unmasked & s_q.severity); // R21
  end

  // single power-on reset; every register here is sticky or bus state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.status <= uer_pkg::STATUS_RESET;
      s_q.mask <= uer_pkg::MASK_RESET;
      s_q.severity <= uer_pkg::SEVERITY_RESET;
      s_q.fep <= uer_pkg::FEP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // all checks run on the one core clock
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  sequence capRead;
    s_axi_arvalid && arReady && hit(s_axi_araddr, uer_pkg::OFF_CAP_HEADER);
  endsequence

  sequence firstLogged;
    (|unmasked) && logEmpty;
  endsequence

  sequence statusClearWrite;
    writeNow && hit(s_q.awAddr, uer_pkg::OFF_STATUS) && (s_q.wStrb == 4'hF);
  endsequence

  sequence maskFullWrite;
    writeNow && hit(s_q.awAddr, uer_pkg::OFF_MASK) && (s_q.wStrb == 4'hF);
  endsequence

  sequence maskedOnly;
    ((errEvent.detect & uer_pkg::ERR_BITS) != 32'h0) && (unmasked == 32'h0);
  endsequence

  a_cap_id_field: assert property (capRead |=> s_axi_rvalid && s_axi_rdata[15:0] == 16'h0001) // R1
    else $error("capability id wrong");

  a_cap_version_field: assert property (capRead |=> s_axi_rdata[19:16] == 4'h1) // R2
    else $error("capability version wrong");

  a_cap_next_ptr: assert property (capRead |=> s_axi_rdata[31:20] == 12'h140) // R3
    else $error("next capability pointer wrong");

  a_event_sets_status: assert property ((|(errEvent.detect & uer_pkg::ERR_BITS)) |=>
    ((s_q.status & $past(errEvent.detect) & uer_pkg::ERR_BITS) == ($past(errEvent.detect) & uer_pkg::ERR_BITS))) // R5
    else $error("error event not recorded in status");

  a_status_sticky_hold: assert property ((!writeNow && errEvent.detect == 32'h0) |=> $stable(s_q.status)) // R4
    else $error("status changed without event or write");

  a_status_w1c_clear: assert property ((statusClearWrite ##0 (errEvent.detect == 32'h0)) |=>
    ((s_q.status & $past(s_q.wData)) == 32'h0)) // R4 R5
    else $error("write one did not clear status");

  a_mask_blocks_msg: assert property (errMsg.valid |-> $past(unmasked) != 32'h0) // R16
    else $error("message sent for masked event");

  a_unmasked_sends_msg: assert property ((|unmasked) |=> errMsg.valid) // R18
    else $error("unmasked event produced no message");

  a_reserved_read_zero: assert property (((s_q.status | s_q.mask | s_q.severity) & ~uer_pkg::ERR_BITS) == 32'h0) // R20
    else $error("reserved bit set");

  a_fatal_needs_msg: assert property (errMsg.fatal |-> errMsg.valid) // R21
    else $error("fatal flag without message");

  a_first_error_ptr: assert property (firstLogged |=> s_q.fep == $past(firstPos) && !logEmpty) // R23
    else $error("first error pointer wrong");

  a_log_holds: assert property ((!logEmpty && !writeNow) |=> $stable(s_q.hdrLog) && $stable(s_q.fep)) // R22
    else $error("header log overwritten while full");

  a_write_response: assert property (writeNow |=> s_axi_bvalid [*1] ##0 !s_q.awTaken) // R17
    else $error("write response missing");

  a_log_capture: assert property (firstLogged |=> s_q.hdrLog == $past(hdrSwapped)) // R22
    else $error("header log not captured");

  a_masked_no_log: assert property (maskedOnly |=> $stable(s_q.fep) && $stable(s_q.hdrLog)) // R16
    else $error("masked event reached the header log");

  a_no_msg_idle: assert property ((unmasked == 32'h0) |=> !errMsg.valid) // R17
    else $error("message without unmasked event");

  a_fatal_flag: assert property ((|(unmasked & s_q.severity)) |=> errMsg.fatal) // R21
    else $error("unmasked fatal event not flagged");

  a_mask_write_lands: assert property (maskFullWrite |=> s_q.mask == ($past(s_q.wData) & uer_pkg::ERR_BITS)) // R18
    else $error("mask write did not land");

  a_log_stays_full: assert property ((!logEmpty && !writeNow) |=> !logEmpty) // R23
    else $error("log emptied without a status write");

  a_unmapped_write: assert property ((writeNow && !mapped(s_q.awAddr)) |=> s_axi_bresp == uer_pkg::RESP_SLVERR) // R20
    else $error("unmapped write not refused");

endmodule : uer_regs

// *** uer_err_source.sv ***
// error detector and message sink model facing the report registers
module uer_err_source (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [31:0] fire,
  input wire logic [127:0] hdr,
  input uer_pkg::uer_msg_t errMsg,
  output uer_pkg::uer_event_t errEvent,
  output int msgCount,
  output int fatalCount
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      errEvent <= '0;
      msgCount <= 0;
      fatalCount <= 0;
    end else begin
      errEvent.detect <= fire;
      // header only valid with a pulse, so scramble it otherwise
      errEvent.header <= (|fire) ? hdr : ~errEvent.header;
      if (errMsg.valid) msgCount <= msgCount + 1;
      if (errMsg.valid && errMsg.fatal) fatalCount <= fatalCount + 1;
    end
  end
endmodule : uer_err_source

// *** uncorrectable_error_report_regs_test.sv ***
// self-checking bench for the uncorrectable error report registers
module uncorrectable_error_report_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, awValid, awReady, wValid, wReady, bValid, bReady, arValid, arReady, rValid, rReady;
  logic [11:0] awAddr, arAddr;
  logic [31:0] wData, rData, fire, m;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, r;
  logic [127:0] hdr;
  uer_pkg::uer_event_t errEvent;
  uer_pkg::uer_msg_t errMsg;
  int msgCount, fatalCount, errors, comparisons, n;
  uer_regs uer_regs_inst (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady), .errEvent(errEvent), .errMsg(errMsg));
  uer_err_source uer_err_source_inst (.clock(clock), .reset_n(reset_n), .fire(fire), .hdr(hdr),
    .errMsg(errMsg), .errEvent(errEvent), .msgCount(msgCount), .fatalCount(fatalCount));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (errors == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // ready is sampled mid-cycle, where it is settled, and the item moves at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw, w, ta, tw;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clock);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clock);
      ta = awValid && awReady;
      tw = wValid && wReady;
      @(posedge clock);
      if (ta) awValid <= 1'b0;
      if (ta) aw = 1'b1;
      if (tw) wValid <= 1'b0;
      if (tw) w = 1'b1;
    end
    do @(negedge clock); while (bValid !== 1'b1);
    resp = bResp;
    @(posedge clock);
    bReady <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0] vr;
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(negedge clock); while (arReady !== 1'b1);
    @(posedge clock);
    arValid <= 1'b0;
    do @(negedge clock); while (rValid !== 1'b1);
    v = rData;
    vr = rResp;
    @(posedge clock);
    rReady <= 1'b0;
    check(v, e);
    check(32'(vr), 32'(er));
  endtask : rd
  task automatic pulse(input logic [31:0] b);
    @(posedge clock);
    fire <= b;
    @(posedge clock);
    fire <= '0;
    repeat (3) @(posedge clock);
  endtask : pulse
  initial begin
    #300us;
    errors++;
    tally_and_finish;
  end
  initial begin
    {awValid, wValid, bReady, arValid, rReady} = '0;
    awAddr = '0;
    arAddr = '0;
    wData = '0;
    wStrb = 4'hF;
    fire = '0;
    errors = 0;
    comparisons = 0;
    // byte i of the header is i, so the big-endian log layout is easy to predict
    hdr = 128'h0F0E0D0C0B0A09080706050403020100;
    reset_n = 1'b0;
    repeat (12) @(posedge clock);
    reset_n <= 1'b1;
    rd(uer_pkg::OFF_CAP_HEADER, {12'h140, 4'h1, 16'h0001}, uer_pkg::RESP_OKAY);
    wr(uer_pkg::OFF_CAP_HEADER, 32'hFFFFFFFF, r);
    check(32'(r), 32'(uer_pkg::RESP_OKAY));
    rd(uer_pkg::OFF_CAP_HEADER, {12'h140, 4'h1, 16'h0001}, uer_pkg::RESP_OKAY);
    rd(uer_pkg::OFF_STATUS, 32'h00000000, uer_pkg::RESP_OKAY);
    rd(uer_pkg::OFF_MASK, 32'h00000000, uer_pkg::RESP_OKAY);
    rd(uer_pkg::OFF_SEVERITY, 32'h00000011, uer_pkg::RESP_OKAY);
    rd(uer_pkg::OFF_CAP_CTRL, 32'h00000000, uer_pkg::RESP_OKAY);
    // each implemented event alone: set, report, log pointer, then clear
    for (n = 0; n < 32; n++) begin
      if (uer_pkg::ERR_BITS[n]) begin
        m = 32'(msgCount);
        pulse(32'h1 << n);
        rd(uer_pkg::OFF_STATUS, 32'h1 << n, uer_pkg::RESP_OKAY);
        check(32'(msgCount), m + 32'h1);
        rd(uer_pkg::OFF_CAP_CTRL, 32'(n), uer_pkg::RESP_OKAY);
        wr(uer_pkg::OFF_STATUS, 32'h1 << n, r);
        rd(uer_pkg::OFF_STATUS, 32'h00000000, uer_pkg::RESP_OKAY);
      end
    end
    check(32'(fatalCount), 32'h2);
    wr(uer_pkg::OFF_MASK, 32'hFFFFFFFF, r);
    rd(uer_pkg::OFF_MASK, 32'h003FF011, uer_pkg::RESP_OKAY);
    m = 32'(msgCount);
    pulse(32'hFFFFFFFF);
    check(32'(msgCount), m);
    rd(uer_pkg::OFF_STATUS, 32'h003FF011, uer_pkg::RESP_OKAY);
    wr(uer_pkg::OFF_STATUS, 32'hFFFFFFFF, r);
    rd(uer_pkg::OFF_STATUS, 32'h00000000, uer_pkg::RESP_OKAY);
    // masked lower bit must not win the log over the unmasked higher one
    wr(uer_pkg::OFF_MASK, 32'h00001000, r);
    pulse(32'h00005000);
    rd(uer_pkg::OFF_CAP_CTRL, 32'h0000000E, uer_pkg::RESP_OKAY);
    for (n = 0; n < 4; n++) begin
      rd(uer_pkg::OFF_HDR_LOG0 + 12'(4 * n), {8'(4 * n), 8'(4 * n + 1), 8'(4 * n + 2), 8'(4 * n + 3)},
        uer_pkg::RESP_OKAY);
    end
    // severity now fatal everywhere; a new event must not disturb the full log
    wr(uer_pkg::OFF_SEVERITY, 32'hFFFFFFFF, r);
    rd(uer_pkg::OFF_SEVERITY, 32'h003FF011, uer_pkg::RESP_OKAY);
    m = 32'(fatalCount);
    pulse(32'h00200000);
    check(32'(fatalCount), m + 32'h1);
    rd(uer_pkg::OFF_CAP_CTRL, 32'h0000000E, uer_pkg::RESP_OKAY);
    // only byte 2 enabled: bits 21:16 set, bit 12 kept
    wStrb <= 4'h4;
    wr(uer_pkg::OFF_MASK, 32'hFFFFFFFF, r);
    wStrb <= 4'hF;
    rd(uer_pkg::OFF_MASK, 32'h003F1000, uer_pkg::RESP_OKAY);
    wr(12'h200, 32'hFFFFFFFF, r);
    check(32'(r), 32'(uer_pkg::RESP_SLVERR));
    rd(12'h200, 32'h00000000, uer_pkg::RESP_SLVERR);
    tally_and_finish;
  end
endmodule : uncorrectable_error_report_regs_test
